// >>> ach_host_io.sv
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
module ach_host_io (
  input wire logic CLK_I,              // 25 MHz clock
  input wire logic SRST_I,             // synchronous reset, high
  input wire logic [3:0] ADDRESS_I,    // avalon byte address
  input wire logic READ_I,             // avalon read
  input wire logic WRITE_I,            // avalon write
  input wire logic [31:0] WRITEDATA_I, // avalon write data
  input wire logic [3:0] BYTEENABLE_I, // avalon byte enables
  output logic [31:0] READDATA_O,      // avalon read data
  output logic WAITREQUEST_O,          // avalon wait request
  input wire logic INT_SYS_ON_I,       // host interrupt system on
  output logic IRQ_O,                  // interrupt request to host
  input wire logic RXD_I,              // serial receive line
  output logic TXD_O,                  // serial transmit line
  input wire logic CTS_I,              // clear to send
  input wire logic DSR_I,              // data set ready
  input wire logic RING_I,             // ring indicator
  input wire logic LINE_DET_I,         // received line signal detector
  input wire logic SEC_RX_I,           // secondary receive line
  output logic RTS_O,                  // request to send
  output logic DTR_O,                  // data terminal ready
  output logic SEC_TX_O,               // secondary transmit line
  output logic DMA_MODE_O,             // dma transfer mode
  input wire logic EXT_CLK_I,          // external 16x clock
  input wire logic [3:0] BAUD_JMP_I,   // strapped baud code
  input wire logic BAUD_JMP_USE_I      // use strapped code
);
  // ==========================================================
  // pin synchronisers
  logic [ach_pkg::SYNC_W-1:0] pins;
  logic [ach_pkg::SYNC_W-1:0] sync1_q;
  logic [ach_pkg::SYNC_W-1:0] sync2_q;

  assign pins = {INT_SYS_ON_I, BAUD_JMP_USE_I, BAUD_JMP_I, EXT_CLK_I,
                 SEC_RX_I, LINE_DET_I, RING_I, DSR_I, CTS_I, RXD_I};

  // two flops per pin, idle high
  generate
    for (genvar i = 0; i < ach_pkg::SYNC_W; i++) begin : g_sync
      always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
          sync1_q[i] <= 1'b1;
          sync2_q[i] <= 1'b1;
        end else begin
          sync1_q[i] <= pins[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  logic rxd;
  logic int_on;
  logic [4:0] lines;
  logic [3:0] baud_code;
  logic [3:0] baud_q;
  logic tick;

  assign rxd = sync2_q[0];
  assign lines = {sync2_q[1], sync2_q[2], sync2_q[3], sync2_q[4],
                  sync2_q[5]};
  assign int_on = sync2_q[12];
  // strapped code overrides the programmed one
  assign baud_code = sync2_q[11] ? sync2_q[10:7] : baud_q;

  ach_baud u_baud (
    .CLK_I(CLK_I),
    .SRST_I(SRST_I),
    .code_i(baud_code),
    .ext_clk_i(sync2_q[6]),
    .tick_o(tick)
  );

  // ==========================================================
  // avalon slave: one wait cycle, then answer
  logic ack_q;
  logic fire_wr;
  logic fire_rd;
  logic [31:0] rd_mux;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ack_q <= 1'b0;
      WAITREQUEST_O <= 1'b1;
      READDATA_O <= 32'h0000_0000;
    end else if ((READ_I | WRITE_I) & ~ack_q) begin
      ack_q <= 1'b1;
      WAITREQUEST_O <= 1'b0;
      READDATA_O <= rd_mux;
    end else begin
      ack_q <= 1'b0;
      WAITREQUEST_O <= 1'b1;
    end
  end

  assign fire_wr = WRITE_I & ack_q;
  assign fire_rd = READ_I & ack_q;

  // ==========================================================
  // instruction and word decode
  logic [15:0] wd;
  logic wr_out;
  logic mr;
  logic wr_word;
  logic instr;
  logic set_control_instr;
  logic clear_control_instr;
  logic set_flag_instr;
  logic clear_flag_instr;

  // a typed output word accepted this cycle
  function automatic logic wt_hit(input logic en, input logic [15:0] w,
                                  input logic [2:0] t);
    return en && (w[ach_pkg::WT_MSB:ach_pkg::WT_LSB] == t);
  endfunction

  assign wd = WRITEDATA_I[15:0];
  assign wr_out = fire_wr && ADDRESS_I == ach_pkg::OFS_WORD_OUT &&
                  BYTEENABLE_I[1:0] == 2'h3;
  assign mr = SRST_I | (wr_out & wd[ach_pkg::MR_BIT]);
  assign wr_word = wr_out & ~wd[ach_pkg::MR_BIT];
  assign instr = fire_wr && ADDRESS_I == ach_pkg::OFS_INSTR &&
                 BYTEENABLE_I[0];
  assign set_control_instr = instr & WRITEDATA_I[ach_pkg::IN_STC];
  assign clear_control_instr = instr & WRITEDATA_I[ach_pkg::IN_CLC];
  assign set_flag_instr = instr & WRITEDATA_I[ach_pkg::IN_STF];
  assign clear_flag_instr = instr & WRITEDATA_I[ach_pkg::IN_CLF];

  // ==========================================================
  // programmed control words
  logic xmit_q;
  logic [4:0] dsie_q;
  logic [4:0] dsref_q;
  logic [7:0] fmt_q;

  // mode bits drop on master reset; baud and format survive
  always_ff @(posedge CLK_I) begin
    if (mr) begin
      xmit_q <= 1'b0;
      RTS_O <= 1'b0;
      DTR_O <= 1'b0;
      SEC_TX_O <= 1'b0;
      DMA_MODE_O <= 1'b0;
      dsie_q <= 5'h00;
      dsref_q <= 5'h00;
    end else begin
      if (wt_hit(wr_word, wd, ach_pkg::WT_CTRL)) begin
        xmit_q <= wd[ach_pkg::C4_XMIT];
        RTS_O <= wd[ach_pkg::C4_RTS];
        DTR_O <= wd[ach_pkg::C4_DTR];
        SEC_TX_O <= wd[ach_pkg::C4_SEC];
        DMA_MODE_O <= wd[ach_pkg::C4_DMA];
      end
      if (wt_hit(wr_word, wd, ach_pkg::WT_DSIE)) begin
        dsie_q <= wd[4:0];
      end
      if (wt_hit(wr_word, wd, ach_pkg::WT_DSREF)) begin
        dsref_q <= wd[4:0];
      end
    end
  end

  // baud only from the control word, format only from its own word
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      baud_q <= ach_pkg::RST_BAUD;
      fmt_q <= ach_pkg::RST_FMT;
    end else begin
      if (wt_hit(wr_word, wd, ach_pkg::WT_CTRL)) begin
        baud_q <= wd[3:0];
      end
      if (wt_hit(wr_word, wd, ach_pkg::WT_FMT)) begin
        fmt_q <= wd[7:0];
      end
    end
  end

  // ==========================================================
  // receiver, 8 data bits and one stop bit
  ach_pkg::ach_rx_t rx_st_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_done_q;
  logic rx_brk_q;

  always_ff @(posedge CLK_I) begin
    rx_done_q <= 1'b0;
    rx_brk_q <= 1'b0;
    if (mr | xmit_q) begin
      rx_st_q <= ach_pkg::RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_st_q)
        ach_pkg::RX_IDLE: begin
          rx_sub_q <= 4'h0;
          if (!rxd) begin
            rx_st_q <= ach_pkg::RX_START;
          end
        end
        ach_pkg::RX_START: begin
          if (rx_sub_q == 4'h7) begin
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_st_q <= rxd ? ach_pkg::RX_IDLE : ach_pkg::RX_DATA;
          end
        end
        ach_pkg::RX_DATA: begin
          if (rx_sub_q == 4'hF) begin
            rx_sh_q <= {rxd, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h7) begin
              rx_st_q <= ach_pkg::RX_STOP;
            end
          end
        end
        ach_pkg::RX_STOP: begin
          if (rx_sub_q == 4'hF) begin
            rx_st_q <= ach_pkg::RX_IDLE;
            if (!rxd && rx_sh_q == 8'h00) begin
              rx_brk_q <= 1'b1;
            end else begin
              rx_done_q <= 1'b1;
            end
          end
        end
        default: rx_st_q <= ach_pkg::RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // transmitter
  ach_pkg::ach_tx_t tx_st_q;
  logic [3:0] tx_sub_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;
  logic tx_done_q;
  logic count_q;
  logic control_q;
  logic [7:0] buf_q;

  always_ff @(posedge CLK_I) begin
    tx_done_q <= 1'b0;
    if (mr) begin
      tx_st_q <= ach_pkg::TX_IDLE;
      TXD_O <= 1'b1;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1FF;
    end else begin
      case (tx_st_q)
        ach_pkg::TX_IDLE: begin
          if (xmit_q & control_q & count_q & ~tx_done_q) begin
            tx_st_q <= ach_pkg::TX_SEND;
            TXD_O <= 1'b0;
            tx_sh_q <= {1'b1, buf_q};
            tx_sub_q <= 4'h0;
            tx_bit_q <= 4'h0;
          end
        end
        ach_pkg::TX_SEND: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == 4'hF) begin
              if (tx_bit_q == 4'h9) begin
                tx_st_q <= ach_pkg::TX_IDLE;
                tx_done_q <= 1'b1;
              end else begin
                TXD_O <= tx_sh_q[0];
                tx_sh_q <= {1'b1, tx_sh_q[8:1]};
                tx_bit_q <= tx_bit_q + 4'h1;
              end
            end
          end
        end
        default: tx_st_q <= ach_pkg::TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // character buffer and count
  logic rd_data;

  assign rd_data = fire_rd && ADDRESS_I == ach_pkg::OFS_WORD_IN &&
                   control_q && !xmit_q;

  always_ff @(posedge CLK_I) begin
    if (mr) begin
      count_q <= 1'b0;
      buf_q <= 8'h00;
    end else if (rx_done_q) begin
      count_q <= 1'b1;
      buf_q <= rx_sh_q;
    end else if (wt_hit(wr_word, wd, ach_pkg::WT_DATA)) begin
      count_q <= 1'b1;
      buf_q <= wd[7:0];
    end else if (tx_done_q | rd_data) begin
      count_q <= 1'b0;
    end
  end

  // ==========================================================
  // latched causes: a new event beats a clear in the same cycle
  logic ovr_q;
  logic brk_q;
  logic empty_q;
  logic full_q;
  logic clr5;
  logic dev_int;

  assign clr5 = wt_hit(wr_word, wd, ach_pkg::WT_CLR);
  assign dev_int = |((lines ^ dsref_q) & dsie_q);

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ovr_q <= 1'b0;
      brk_q <= 1'b0;
      empty_q <= 1'b0;
      full_q <= 1'b0;
    end else begin
      ovr_q <= (rx_done_q & count_q) |
               (ovr_q & ~(clr5 & wd[ach_pkg::C5_OVR]));
      brk_q <= rx_brk_q | (brk_q & ~(clr5 & wd[ach_pkg::C5_BRK]));
      empty_q <= tx_done_q | (empty_q & ~(clr5 & wd[ach_pkg::C5_EMPTY]));
      full_q <= rx_done_q | (full_q & ~(clr5 & wd[ach_pkg::C5_FULL]));
    end
  end

  // ==========================================================
  // control flip-flop, flag, lockout and request
  logic flag_q;
  logic lockout_q;
  logic hw_set;

  assign hw_set = (ovr_q | brk_q | empty_q | full_q | dev_int) &
                  ~lockout_q & ~flag_q;

  // set-control then clear-control in one write leaves it clear
  always_ff @(posedge CLK_I) begin
    if (mr) begin
      control_q <= 1'b0;
    end else if (clear_control_instr) begin
      control_q <= 1'b0;
    end else if (set_control_instr) begin
      control_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (mr) begin
      flag_q <= 1'b1;
    end else if (hw_set | set_flag_instr) begin
      flag_q <= 1'b1;
    end else if (clear_flag_instr) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (mr | hw_set) begin
      lockout_q <= 1'b1;
    end else if (set_control_instr) begin
      lockout_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= flag_q & control_q & int_on & ~clear_flag_instr;
    end
  end

  // ==========================================================
  // read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ADDRESS_I)
      ach_pkg::OFS_WORD_IN: begin
        if (control_q) begin
          rd_mux[15] = count_q;
          rd_mux[8] = count_q;
          rd_mux[7:0] = buf_q;
        end else begin
          rd_mux[15] = dev_int;
          rd_mux[8:5] = {full_q, empty_q, brk_q, ovr_q};
          rd_mux[4:0] = lines;
        end
      end
      ach_pkg::OFS_INSTR: begin
        rd_mux[4:0] = {IRQ_O, int_on, lockout_q, flag_q, control_q};
      end
      ach_pkg::OFS_MODE: begin
        rd_mux[16:0] = {xmit_q, RTS_O, DTR_O, SEC_TX_O, DMA_MODE_O,
                        fmt_q, baud_code};
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end
endmodule

// >>> ach_pkg.sv
package ach_pkg;
  // ==========================================================
  // clocking and serial timing
  localparam int CLK_HZ = 25_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int SYNC_W = 13;
  // baud figures in tenths, indexed by the four-bit code
  localparam int BAUD_X10 [16] = '{0, 500, 750, 1100, 1345, 1500,
    3000, 6000, 9000, 12000, 18000, 24000, 36000, 48000, 72000, 96000};
  localparam logic [3:0] BAUD_EXT = 4'h0;

  // ==========================================================
  // bus byte offsets
  localparam logic [3:0] OFS_WORD_OUT = 4'h0;
  localparam logic [3:0] OFS_WORD_IN = 4'h4;
  localparam logic [3:0] OFS_INSTR = 4'h8;
  localparam logic [3:0] OFS_MODE = 4'hC;

  // ==========================================================
  // output word fields
  localparam int MR_BIT = 15;
  localparam int WT_MSB = 14;
  localparam int WT_LSB = 12;
  localparam logic [2:0] WT_DATA = 3'h0;
  localparam logic [2:0] WT_DSIE = 3'h1;
  localparam logic [2:0] WT_DSREF = 3'h2;
  localparam logic [2:0] WT_FMT = 3'h3;
  localparam logic [2:0] WT_CTRL = 3'h4;
  localparam logic [2:0] WT_CLR = 3'h5;
  localparam int C4_XMIT = 8;
  localparam int C4_RTS = 7;
  localparam int C4_DTR = 6;
  localparam int C4_SEC = 5;
  localparam int C4_DMA = 4;
  localparam int C5_OVR = 0;
  localparam int C5_BRK = 1;
  localparam int C5_EMPTY = 2;
  localparam int C5_FULL = 3;

  // ==========================================================
  // instruction register bits
  localparam int IN_STC = 0;
  localparam int IN_CLC = 1;
  localparam int IN_STF = 2;
  localparam int IN_CLF = 3;

  // ==========================================================
  // reset values
  localparam logic [3:0] RST_BAUD = 4'h0;
  localparam logic [7:0] RST_FMT = 8'h00;

  // ==========================================================
  // state types
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ach_rx_t;
  typedef enum logic {TX_IDLE, TX_SEND} ach_tx_t;
endpackage

// >>> ach_baud.sv
module ach_baud (
  input wire logic CLK_I,        // system clock
  input wire logic SRST_I,       // synchronous reset
  input wire logic [3:0] code_i, // active baud code
  input wire logic ext_clk_i,    // synchronised external 16x clock
  output logic tick_o            // one-cycle 16x sample enable
);
  // ==========================================================
  // divisor lookup
  function automatic logic [15:0] div_of(input logic [3:0] c);
    int d;
    d = 1;
    if (c != ach_pkg::BAUD_EXT) begin
      d = (ach_pkg::CLK_HZ * 10) /
          (ach_pkg::OVERSAMPLE * ach_pkg::BAUD_X10[c]);
    end
    return d[15:0];
  endfunction

  logic [15:0] cnt_q;
  logic [15:0] div;
  logic ext_prev_q;

  assign div = div_of(code_i);

  // ==========================================================
  // rate divider, or edge of the external clock for code zero
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      cnt_q <= 16'h0000;
      ext_prev_q <= 1'b1; // matches the synchroniser's idle level
      tick_o <= 1'b0;
    end else begin
      ext_prev_q <= ext_clk_i;
      if (code_i == ach_pkg::BAUD_EXT) begin
        cnt_q <= 16'h0000;
        tick_o <= ext_clk_i & ~ext_prev_q;
      end else if (cnt_q >= div - 16'h0001) begin
        cnt_q <= 16'h0000;
        tick_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        tick_o <= 1'b0;
      end
    end
  end
endmodule

// >>> ach_host_io_properties.sv
module ach_host_io_properties (
  input wire logic CLK_I, // clock
  input wire logic SRST_I, // sync reset
  input wire logic [3:0] ADDRESS_I, // bus address
  input wire logic READ_I, // bus read
  input wire logic WRITE_I, // bus write
  input wire logic [31:0] WRITEDATA_I, // bus write data
  input wire logic [3:0] BYTEENABLE_I, // byte enables
  input wire logic [31:0] READDATA_O, // bus read data
  input wire logic WAITREQUEST_O, // bus wait
  input wire logic INT_SYS_ON_I, // interrupt system on
  input wire logic IRQ_O, // interrupt request
  input wire logic TXD_O, // serial out
  input wire logic RTS_O, // request to send
  input wire logic DTR_O, // terminal ready
  input wire logic DMA_MODE_O // dma mode
);
  logic take_wr, ins_wr, mr_take, stc_take, clf_take, armed_q;

  // ==========================================================
  // accepted writes, decoded at the edge that completes them
  assign take_wr = WRITE_I && !WAITREQUEST_O;
  assign ins_wr = take_wr && ADDRESS_I == ach_pkg::OFS_INSTR
    && BYTEENABLE_I[0];
  assign mr_take = take_wr && ADDRESS_I == ach_pkg::OFS_WORD_OUT
    && WRITEDATA_I[ach_pkg::MR_BIT] && (&BYTEENABLE_I[1:0]);
  assign stc_take = ins_wr && WRITEDATA_I[ach_pkg::IN_STC];
  assign clf_take = ins_wr && WRITEDATA_I[ach_pkg::IN_CLF]
    && !WRITEDATA_I[ach_pkg::IN_STF];

  // a new request may rise only after set-control or a system change
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      armed_q <= 1'b0;
    end else if (stc_take || $changed(INT_SYS_ON_I)) begin
      armed_q <= 1'b1;
    end else if ($rose(IRQ_O)) begin
      armed_q <= 1'b0;
    end
  end

  // ==========================================================
  // properties
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  property p_wait_one;
    !WAITREQUEST_O |=> WAITREQUEST_O;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low twice");

  property p_answer;
    (READ_I || WRITE_I) && WAITREQUEST_O |-> ##[1:2] !WAITREQUEST_O;
  endproperty
  a_answer: assert property (p_answer) else $error("request unanswered");

  property p_mr_out;
    mr_take |=> (!RTS_O && !DTR_O && !DMA_MODE_O) ##1 !IRQ_O;
  endproperty
  a_mr_out: assert property (p_mr_out) else $error("reset word ignored");

  property p_mr_txd;
    mr_take |=> TXD_O [*8];
  endproperty
  a_mr_txd: assert property (p_mr_txd) else $error("send not aborted");

  property p_clf;
    clf_take |-> ##[1:2] !IRQ_O;
  endproperty
  a_clf: assert property (p_clf) else $error("request not withdrawn");

  property p_lock;
    $rose(IRQ_O) |-> armed_q;
  endproperty
  a_lock: assert property (p_lock) else $error("nested request");

  property p_int_off;
    !INT_SYS_ON_I [*5] |-> !IRQ_O;
  endproperty
  a_int_off: assert property (p_int_off) else $error("request while off");

  property p_unmapped;
    READ_I && !WAITREQUEST_O && (ADDRESS_I[1:0] != 2'h0
      || ADDRESS_I == ach_pkg::OFS_WORD_OUT) |-> READDATA_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad read data");
endmodule

// >>> ach_term.sv
module ach_term #(
  parameter int BIT_CYC = 64
) (
  input wire logic clk_i, // bench clock
  input wire logic txd_i, // line from the device
  output logic rxd_o // line into the device
);
  logic [7:0] got_char;
  int got_cnt;

  // ==========================================================
  // one 8N1 frame to the device, lsb first, line idles at mark
  initial rxd_o = 1'b1;
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask

  // capture frames from the device, sampled in mid bit
  initial begin
    got_cnt = 0;
    forever begin
      @(negedge txd_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_i);
        got_char[i] = txd_i;
      end
      repeat (BIT_CYC) @(posedge clk_i);
      got_cnt++;
    end
  end
endmodule

// >>> ach_host_io_tb.sv
module ach_host_io_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] a_out = ach_pkg::OFS_WORD_OUT;
  localparam logic [3:0] a_in = ach_pkg::OFS_WORD_IN;
  localparam logic [3:0] a_ins = ach_pkg::OFS_INSTR;
  localparam logic [3:0] a_mode = ach_pkg::OFS_MODE;
  localparam logic [31:0] set_control_instr = 32'h1 << ach_pkg::IN_STC;
  localparam logic [31:0] clear_control_instr = 32'h1 << ach_pkg::IN_CLC;
  localparam logic [31:0] set_flag_instr = 32'h1 << ach_pkg::IN_STF;
  localparam logic [31:0] clear_flag_instr = 32'h1 << ach_pkg::IN_CLF;
  logic clk, srst, rd, wr, int_on, irq, rxd, txd, ext, use_jmp;
  logic rts, dtr, sec, dma, wait_rq;
  logic [3:0] addr, be, jmp;
  logic [4:0] modem;
  logic [7:0] c, f8;
  logic [31:0] wdata, rdata, rdat, r;
  logic [3:0] codes [3] = '{4'h9, 4'hF, 4'h0};
  int seed, num_errors, num_checks, n;

  // ==========================================================
  // design, terminal model and clocks
  ach_host_io ach_host_io_inst (.CLK_I(clk), .SRST_I(srst),
    .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wdata),
    .BYTEENABLE_I(be), .READDATA_O(rdata), .WAITREQUEST_O(wait_rq),
    .INT_SYS_ON_I(int_on), .IRQ_O(irq), .RXD_I(rxd), .TXD_O(txd),
    .CTS_I(modem[4]), .DSR_I(modem[3]), .RING_I(modem[2]),
    .LINE_DET_I(modem[1]), .SEC_RX_I(modem[0]), .RTS_O(rts),
    .DTR_O(dtr), .SEC_TX_O(sec), .DMA_MODE_O(dma), .EXT_CLK_I(ext),
    .BAUD_JMP_I(jmp), .BAUD_JMP_USE_I(use_jmp));
  ach_term ach_term_inst (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // external 16x clock, one rise every four cycles
  initial begin
    ext = 1'b0;
    forever begin
      repeat (2) @(posedge clk);
      ext <= ~ext;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic lapse(input int k, input int lim);
    if (k >= lim) begin
      num_errors++;
      give_verdict();
    end
  endtask
  // one bus transfer, held until wait is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wait_rq !== 1'b0 && k < 20);
    lapse(k, 20);
    rdat = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] word(input logic [2:0] t,
                                       input logic [11:0] f);
    return {17'h0, t, f};
  endfunction
  function automatic logic [31:0] ins(input logic [4:0] b);
    return {27'h0, b};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    seed = 71428;
    num_errors = 0;
    num_checks = 0;
    {srst, rd, wr, addr, wdata, be} = {3'b100, 4'h0, 32'h0, 4'hF};
    {int_on, use_jmp, jmp} = {2'b11, 4'h0};
    modem = 5'($random(seed));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b01110));
    bus(0, a_in, 0);
    chk(rdat, 32'(modem));
    bus(1, a_out, word(1, 12'h01F));
    bus(1, a_out, word(2, {7'h0, ~modem}));
    bus(0, a_in, 0);
    chk(rdat, {16'h0, 1'b1, 10'h0, modem});
    bus(0, 4'h2, 0);
    chk(rdat, 32'h0);
    bus(0, a_out, 0);
    chk(rdat, 32'h0);
    for (int i = 0; i < 3; i++) begin
      jmp <= codes[i];
      repeat (4) @(posedge clk);
      bus(0, a_mode, 0);
      chk(32'(rdat[3:0]), 32'(codes[i]));
    end
    use_jmp <= 1'b0;
    repeat (4) begin
      r = $random(seed);
      bus(1, a_out, word(4, {4'h0, r[3:0], r[7:4]}));
      chk(32'({rts, dtr, sec, dma}), 32'(r[3:0]));
      bus(0, a_mode, 0);
      chk(32'(rdat[15:12]), 32'(r[3:0]));
      chk(32'(rdat[3:0]), 32'(r[7:4]));
    end
    f8 = 8'($random(seed));
    bus(1, a_out, word(3, {4'h0, f8}));
    bus(1, a_out, word(4, 12'h1F0));
    r = $random(seed);
    bus(1, a_out, {16'h0, 1'b1, r[14:0]});
    chk(32'({rts, dtr, dma, txd}), 32'h1);
    bus(0, a_mode, 0);
    chk(32'({rdat[16:14], rdat[12:0]}), {20'h0, f8, 4'h0});
    bus(0, a_in, 0);
    chk(32'(rdat[15]), 32'h0);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b01110));
    bus(1, a_ins, clear_flag_instr);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b01100));
    c = 8'($random(seed));
    ach_term_inst.send(c);
    n = 0;
    do begin
      bus(0, a_in, 0);
      n++;
    end while (rdat[8] !== 1'b1 && n < 30);
    lapse(n, 30);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b01100));
    bus(1, a_ins, set_control_instr);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b11111));
    bus(0, a_in, 0);
    chk(rdat, {16'h0, 8'h81, c});
    bus(0, a_in, 0);
    chk(32'({rdat[15], rdat[8]}), 32'h0);
    bus(1, a_ins, clear_control_instr);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b01110));
    bus(0, a_in, 0);
    chk(32'(rdat[8]), 32'h1);
    bus(1, a_ins, clear_flag_instr);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b01100));
    bus(1, a_ins, set_flag_instr);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b01110));
    bus(1, a_ins, set_control_instr);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    int_on <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(irq), 32'h0);
    int_on <= 1'b1;
    bus(1, a_out, word(5, 12'h00F));
    bus(1, a_ins, set_control_instr | clear_flag_instr);
    repeat (3) @(posedge clk);
    bus(0, a_ins, 0);
    chk(rdat, ins(5'b01001));
    c = 8'($random(seed));
    bus(1, a_out, word(4, 12'h100));
    bus(1, a_out, word(0, {4'h0, c}));
    bus(1, a_ins, set_control_instr);
    n = 0;
    while (ach_term_inst.got_cnt == 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    lapse(n, 2000);
    chk(32'(ach_term_inst.got_char), 32'(c));
    repeat (48) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(1, a_ins, clear_control_instr);
    bus(0, a_in, 0);
    chk(32'(rdat[7]), 32'h1);
    give_verdict();
  end
endmodule

bind ach_host_io ach_host_io_properties ach_host_io_properties_inst (
  .CLK_I, .SRST_I, .ADDRESS_I, .READ_I, .WRITE_I, .WRITEDATA_I,
  .BYTEENABLE_I, .READDATA_O, .WAITREQUEST_O, .INT_SYS_ON_I, .IRQ_O,
  .TXD_O, .RTS_O, .DTR_O, .DMA_MODE_O
);
